// ---- icc_pkg.sv ----
// Package and slot matcher for the interrupt class combiner.
// Assumes every request comes from logic on the core clock.
`timescale 1ns/1ps

package icc_pkg;
    // ==========================================================
    // Sizes and reset values
    localparam int ICC_NSRC = 32;
    localparam int ICC_NSLOT = 16;
    localparam int ICC_SRCW = 5;
    localparam int ICC_SLOTW = 4;
    localparam logic [ICC_NSRC-1:0] ICC_SRC_RST = 32'h0000_0000;
    localparam logic [ICC_SLOTW-1:0] ICC_SLOT_RST = 4'h0;

    // One vectored priority slot; slot 0 is the highest priority
    typedef struct packed {
        logic en;
        logic [ICC_SRCW-1:0] src;
    } icc_slot_cfg_t;

    // Normal-class answer to the core
    typedef struct packed {
        logic req;
        logic vec_valid;
        logic [ICC_SLOTW-1:0] slot;
        logic [ICC_SRCW-1:0] src;
    } icc_norm_t;
endpackage

// ==========================================================
// Slot matcher: one slot claims its source when enabled
module icc_slot_match
    import icc_pkg::*;
(
    input wire icc_slot_cfg_t i_cfg,
    input wire logic [ICC_NSRC-1:0] i_norm_req,
    output logic [ICC_NSRC-1:0] o_claim,
    output logic o_hit
);
    // Claim decode and hit for this slot
    always_comb begin
        o_claim = '0;
        o_claim[i_cfg.src] = i_cfg.en;
        o_hit = i_cfg.en & i_norm_req[i_cfg.src];
    end
endmodule

// ---- icc_top.sv ----
// Interrupt class combiner top: sorts requests into fast, vectored
// and non-vectored classes and drives the core's two request lines.
// Assumes requests and settings are on i_core_clk; no sync needed.
//
// Summary of operation
// RQ1 - Every enabled source sorted into one of three classes
// RQ2 - Class and priority settings changeable live, no reset
// RQ3 - Fast class outranks both normal classes
// RQ4 - Any active fast source raises fast request
// RQ5 - Readable word shows active fast sources
// RQ6 - Vectored by slot order, non-vectored last

`timescale 1ns/1ps

module icc_top
    import icc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [ICC_NSRC-1:0] i_irq_req,
    input wire logic [ICC_NSRC-1:0] i_src_enable,
    input wire logic [ICC_NSRC-1:0] i_fast_sel,
    input wire icc_slot_cfg_t [ICC_NSLOT-1:0] i_slot_cfg,
    output logic o_fast_interrupt_request,
    output logic [ICC_NSRC-1:0] o_fast_status,
    output logic o_normal_request,
    output logic o_vec_valid,
    output logic [ICC_SLOTW-1:0] o_vec_slot,
    output logic [ICC_SRCW-1:0] o_vec_src,
    output logic o_nonvec_active
);
    // ==========================================================
    // Classification
    logic [ICC_NSRC-1:0] live;
    logic [ICC_NSRC-1:0] fast_act;
    logic [ICC_NSRC-1:0] norm_act;
    logic [ICC_NSRC-1:0] claim [ICC_NSLOT];
    logic [ICC_NSRC-1:0] vec_mask;
    logic [ICC_NSLOT-1:0] hit;

    // Settings are read every cycle, so a change reaches the outputs at the next enabled edge.
    // A disabled source is in no class; a source with its fast bit set
    // is fast only, even when a slot also names it
    always_comb begin
        live = i_irq_req & i_src_enable;
        fast_act = live & i_fast_sel; // RQ1
        norm_act = live & ~i_fast_sel; // RQ1 RQ2
    end

    // One matcher per slot. It only sees the normal-class vector, so a
    // slot that names a fast or disabled source never hits
    genvar g;
    generate
        for (g = 0; g < ICC_NSLOT; g++) begin : g_slot
            icc_slot_match u_match (
                .i_cfg(i_slot_cfg[g]),
                .i_norm_req(norm_act),
                .o_claim(claim[g]),
                .o_hit(hit[g])
            );
        end
    endgenerate

    // Sources owned by any enabled slot are vectored
    always_comb begin
        vec_mask = '0;
        for (int s = 0; s < ICC_NSLOT; s++) begin
            vec_mask = vec_mask | claim[s];
        end
    end

    // ==========================================================
    // Output registers
    logic fast_req_q, fast_req_d;
    logic [ICC_NSRC-1:0] fstat_q, fstat_d;
    // The normal-class answer travels as one struct so it updates as a unit
    icc_norm_t norm_q, norm_d;
    logic nonvec_q, nonvec_d;

    // Next values: lowest slot wins, non-vectored ranks below all slots
    always_comb begin
        fast_req_d = |fast_act; // RQ4
        fstat_d = fast_act; // RQ5
        norm_d = '0;
        // Scan from the lowest priority up so the last write is slot 0;
        // several slots may name one source and the lowest still wins
        for (int s = ICC_NSLOT - 1; s >= 0; s--) begin
            if (hit[s]) begin
                norm_d.vec_valid = 1'b1; // RQ6
                norm_d.slot = ICC_SLOTW'(s);
                norm_d.src = i_slot_cfg[s].src;
            end
        end
        nonvec_d = |(norm_act & ~vec_mask) & ~norm_d.vec_valid; // RQ6
        // Normal line held off while fast is up, so the core never sees
        // both and always services fast first
        norm_d.req = (|norm_act) & ~fast_req_d; // RQ3
    end

    // Register stage; clock enable freezes everything. The core only ever
    // sees flop outputs, so no glitch from a request input reaches it; the
    // price is one cycle of latency
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            fast_req_q <= 1'b0;
            fstat_q <= ICC_SRC_RST;
            norm_q <= '0;
            nonvec_q <= 1'b0;
        end else if (i_ce) begin
            fast_req_q <= fast_req_d;
            fstat_q <= fstat_d;
            norm_q <= norm_d;
            nonvec_q <= nonvec_d;
        end
    end

    assign o_fast_interrupt_request = fast_req_q;
    assign o_fast_status = fstat_q;
    assign o_normal_request = norm_q.req;
    assign o_vec_valid = norm_q.vec_valid;
    assign o_vec_slot = norm_q.slot;
    assign o_vec_src = norm_q.src;
    assign o_nonvec_active = nonvec_q;

    // ==========================================================
    // Checks
    // All checks run on the core clock and pause while reset is high
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    AST_CLASS_FAST: assert property (i_ce |=> // RQ1
        o_fast_status == $past(i_irq_req & i_src_enable & i_fast_sel))
        else $error("fast status does not match fast-class requests");
    AST_LIVE_CHANGE: assert property ((i_ce && $changed(i_fast_sel)) |=> // RQ2
        o_fast_status == $past(live & i_fast_sel))
        else $error("class change not applied next cycle");
    AST_FAST_FIRST: assert property (o_fast_interrupt_request |-> // RQ3
        !o_normal_request)
        else $error("normal request shown while fast active");
    AST_FAST_OR: assert property (o_fast_interrupt_request == // RQ4
        (|o_fast_status))
        else $error("fast request not the OR of fast status");
    AST_STATUS_FOLLOW: assert property ((i_ce && (fast_act != '0)) |=> // RQ5
        (o_fast_status != '0) && o_fast_interrupt_request)
        else $error("active fast source missing from status");
    AST_VEC_PRIO: assert property ((i_ce && hit[0]) |=> // RQ6
        o_vec_valid && o_vec_slot == 4'h0)
        else $error("slot 0 hit not selected");
    AST_NONVEC_BELOW: assert property (o_nonvec_active |-> !o_vec_valid) // RQ6
        else $error("non-vectored shown above vectored");
    AST_NORM_LINE: assert property ((i_ce && (norm_act != '0) && (fast_act == '0)) // RQ6
        |=> o_normal_request)
        else $error("normal request missing");

    // ==========================================================
    // Further fast-class checks
    // A quiet fast class must drop the core's fast line next cycle
    AST_FAST_IDLE: assert property ((i_ce && (fast_act == '0)) // RQ4
        |=> !o_fast_interrupt_request)
        else $error("fast request without an active fast source");

    // Any fast source holds off the normal line, whatever normal wants
    AST_FAST_MASK: assert property ((i_ce && (fast_act != '0)) // RQ3
        |=> !o_normal_request)
        else $error("normal request not held off by fast class");

    // A status bit clears once its source leaves the fast class
    AST_STATUS_OFF: assert property ((i_ce && !fast_act[0]) // RQ5
        |=> !o_fast_status[0])
        else $error("stale fast status bit for source 0");

    // A disabled source belongs to no class at all
    AST_SRC_OFF: assert property ((i_ce && !i_src_enable[0]) // RQ1
        |=> !o_fast_status[0])
        else $error("disabled source shown in fast status");

    // ==========================================================
    // Further normal-class checks
    // Any slot hit must be reported as a vectored request
    AST_VEC_ANY: assert property ((i_ce && (hit != '0)) // RQ6
        |=> o_vec_valid)
        else $error("slot hit not reported as vectored");

    // With no hit the vector fields rest at zero, never stale
    AST_VEC_NONE: assert property ((i_ce && (hit == '0)) // RQ6
        |=> !o_vec_valid && (o_vec_slot == 4'h0) && (o_vec_src == 5'h00))
        else $error("vector fields not cleared without a hit");

    // Slot 0 hands over the source it names
    AST_VEC_SRC0: assert property ((i_ce && hit[0]) // RQ6
        |=> o_vec_src == $past(i_slot_cfg[0].src))
        else $error("slot 0 source not reported");

    // Slot 1 wins only when slot 0 is idle
    AST_VEC_SLOT1: assert property ((i_ce && !hit[0] && hit[1]) // RQ6
        |=> o_vec_valid && (o_vec_slot == 4'h1)
        && (o_vec_src == $past(i_slot_cfg[1].src)))
        else $error("slot 1 not chosen after idle slot 0");

    // An unclaimed normal source shows as non-vectored when no slot hits
    AST_NONVEC_SET: assert property ((i_ce && ((norm_act & ~vec_mask) != '0) // RQ6
        && (hit == '0)) |=> o_nonvec_active)
        else $error("non-vectored request missing");

    // ==========================================================
    // Clock enable
    // A low enable must freeze every output for the following cycle; the
    // core would otherwise see a request that software believes is parked
    AST_CE_FREEZE: assert property (!i_ce |=> // RQ5
        $stable(o_fast_interrupt_request) && $stable(o_fast_status)
        && $stable(o_normal_request) && $stable(o_vec_valid)
        && $stable(o_vec_slot) && $stable(o_vec_src)
        && $stable(o_nonvec_active))
        else $error("outputs moved while clock enable low");

    // ==========================================================
    // Coverage of the main scenarios
    COV_FAST: cover property (o_fast_interrupt_request && $countones(o_fast_status) > 1);
    COV_VEC: cover property (o_vec_valid && o_vec_slot != 4'h0);
    COV_NONVEC: cover property (o_nonvec_active && o_normal_request);
    COV_PREEMPT: cover property (o_normal_request ##1 o_fast_interrupt_request);
endmodule

// ---- icc_core_model.sv ----
// Core-side model: takes the fast request ahead of the normal one.
// Assumes the combiner's outputs are registered on the same clock.
`timescale 1ns/1ps

module icc_core_model (
    input wire logic i_core_clk,
    input wire logic i_fast,
    input wire logic i_normal,
    output logic [1:0] o_taken
);
    // ==========================================================
    // Entry taken each edge; fast wins so a normal never hides it
    always_ff @(posedge i_core_clk) begin
        o_taken <= i_fast ? 2'h2 : (i_normal ? 2'h1 : 2'h0);
    end
endmodule

// ---- tb.sv ----
// Testbench for the interrupt class combiner against an integer model.
// Assumes one-cycle output latency and i_ce freezing the outputs.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
    import icc_pkg::*;
    logic i_core_clk = 0, i_rst = 1, i_ce = 1, o_fir, o_nreq, o_vv, o_nv;
    logic [ICC_NSRC-1:0] i_irq_req = '0, i_src_enable = '0, i_fast_sel = '0, o_fst;
    icc_slot_cfg_t [ICC_NSLOT-1:0] i_slot_cfg = '0;
    logic [ICC_SLOTW-1:0] o_vs;
    logic [ICC_SRCW-1:0] o_vsrc;
    logic [31:0] lf = 32'hcda4, ef = '0;
    logic [11:0] en_q = '0;
    logic [1:0] taken, exp_take = '0;
    int fails = 0, checks = 0;

    // ==========================================================
    // Clock, design and core model
    always #5 i_core_clk = ~i_core_clk;
    icc_top icc_top_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_irq_req(i_irq_req), .i_src_enable(i_src_enable), .i_fast_sel(i_fast_sel),
        .i_slot_cfg(i_slot_cfg), .o_fast_interrupt_request(o_fir), .o_fast_status(o_fst),
        .o_normal_request(o_nreq), .o_vec_valid(o_vv), .o_vec_slot(o_vs),
        .o_vec_src(o_vsrc), .o_nonvec_active(o_nv));
    icc_core_model icc_core_model_inst (.i_core_clk(i_core_clk), .i_fast(o_fir),
        .i_normal(o_nreq), .o_taken(taken));

    function automatic logic [31:0] step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Expected outputs; slots scanned high to low so slot 0 wins
    task automatic model();
        logic [31:0] n, cl;
        int hit;
        n = i_irq_req & i_src_enable & ~i_fast_sel;
        cl = '0;
        hit = -1;
        ef = i_irq_req & i_src_enable & i_fast_sel;
        for (int s = ICC_NSLOT - 1; s >= 0; s--) begin
            if (i_slot_cfg[s].en) begin
                cl[i_slot_cfg[s].src] = 1'b1;
                if (n[i_slot_cfg[s].src]) hit = s;
            end
        end
        en_q = {(|n) && !(|ef), hit >= 0, hit >= 0 ? hit[3:0] : 4'h0,
            hit >= 0 ? i_slot_cfg[hit].src : 5'h00, (|(n & ~cl)) && hit < 0};
    endtask

    task automatic wrap_up();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog sized well past the 2000 cycles of traffic
    initial begin
        #60000;
        fails++;
        wrap_up();
    end

    // Phase 0 keeps fast class empty; phase 1 mixes all classes
    initial begin
        repeat (3) @(posedge i_core_clk);
        #1 i_rst = 0;
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                // Mid-run reset: outputs must clear at once, not at an edge
                @(posedge i_core_clk);
                #1 i_rst = 1;
                i_irq_req = '0;
                i_ce = 1'b1;
                ef = '0;
                en_q = '0;
                exp_take = 2'h0;
                #1;
                `CHK({o_fir, o_fst, o_nreq, o_vv, o_vs, o_vsrc, o_nv}, 45'h0)
                repeat (2) @(posedge i_core_clk);
                #1 i_rst = 0;
            end
            for (int k = 0; k < 1000; k++) begin
                @(posedge i_core_clk);
                #1;
                `CHK(o_fir, |ef)
                `CHK(o_fst, ef)
                `CHK(o_nreq, en_q[11])
                `CHK({o_vv, o_vs, o_vsrc, o_nv}, en_q[10:0])
                `CHK(taken, exp_take)
                // The core takes next edge what stands now, fast first
                exp_take = (|ef) ? 2'h2 : (en_q[11] ? 2'h1 : 2'h0);
                for (int s = 0; s < ICC_NSLOT; s++) begin
                    lf = step(step(step(step(step(step(lf))))));
                    i_slot_cfg[s] = {lf[7] & lf[9], lf[4:0]};
                end
                i_irq_req = lf & step(lf ^ 32'h5a5a);
                lf = step(lf);
                i_src_enable = lf | {lf[15:0], lf[31:16]};
                i_fast_sel = p == 0 ? '0 : lf & step(lf);
                i_ce = |lf[2:0];
                if (i_ce) model();
            end
            $display("test %0d done, fails=%0d", p, fails);
        end
        wrap_up();
    end
endmodule
